// File: tsf_consts.svh
// constants of the timer status flag block
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH
// ================================================================
// register byte offsets
`define TSF_CTRL_OFS 12'h000
`define TSF_MASK_OFS 12'h00c
`define TSF_FLAGS_OFS 12'h010
`define TSF_EVGEN_OFS 12'h014
`define TSF_CCV1_OFS 12'h034
`define TSF_CCV_STEP 12'h004
// ================================================================
// flag register layout
`define TSF_FLAGS_RESET 16'h0000
`define TSF_FLAGS_WMASK 16'h1e5f
`define TSF_UPD_BIT 0
`define TSF_CH_BIT0 1
`define TSF_TRIG_BIT 6
`define TSF_OVC_BIT0 9
// ================================================================
// control register layout
`define TSF_CTRL_UDIS_BIT 0
`define TSF_CTRL_URS_BIT 1
`define TSF_CTRL_CAMS_LSB 5
`define TSF_CTRL_SMS_LSB 8
`define TSF_CTRL_IN_LSB 12
`define TSF_CTRL_POL_LSB 16
`define TSF_CTRL_WMASK 32'h000f_f763
`define TSF_EVGEN_UDG_BIT 0
// ================================================================
// slave mode and center-aligned codes
`define TSF_SMS_RESET 3'h4
`define TSF_SMS_GATED 3'h5
`define TSF_CAMS_EDGE 2'h0
`define TSF_CAMS_DOWN 2'h1
`define TSF_CAMS_UP 2'h2
// ================================================================
// bus answers
`define TSF_RESP_OKAY 2'h0
`define TSF_RESP_SLVERR 2'h2
`endif

// File: tsf_pkg.sv
// types of the timer status flag block
package tsf_pkg;
  typedef logic [15:0] tsf_flags_t;
  typedef logic [1:0] tsf_resp_t;
  typedef logic [2:0] tsf_smode_t;
endpackage

// File: tsf_timer_status_flags.sv
// timer status flags with capture/compare channels and axi4-lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "tsf_consts.svh"

// Functional notes
// - channel 1 overcapture sets only on input capture while its flag is set.
// - overcapture flags clear only by writing zero; writing one keeps them.
// - channels 2 to 4 overcapture flags at bits 10 to 12 behave alike.
// - outside gated mode, each active trigger edge sets the trigger flag.
// - in gated mode any trigger edge sets the flag; software clears it.
// - output channel flag sets on compare match, gated by center-aligned selection.
// - compare above reload sets flag on overflow unless edge-aligned and down-counting, or on underflow when edge-aligned and down-counting.
// - input channel flag sets on capture; cleared by write or capture read.
// - capture latches counter value on an edge of selected polarity.
// - channels 2 to 4 flags at bits 2 to 4 behave like channel 1.
// - update flag sets on overflow or underflow when update is not disabled.
// - software update generation sets update flag when source and disable are zero.
// - flag register at 0x10 resets to zero; reserved bits stay zero.
// - gated mode enables counting while trigger is high, stops without reset.
// - software update reinitialises counter, clears prescaler, bit self-clears.
module tsf_timer_status_flags
  import tsf_pkg::*;
#(
  parameter int CW = 16,
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CW-1:0] counter_value,
  input wire logic [CW-1:0] auto_reload_value,
  input wire logic counter_tick,
  input wire logic counter_overflow,
  input wire logic counter_underflow,
  input wire logic count_down,
  input wire logic trigger_input,
  input wire logic [NCH-1:0] chan_capture_input,
  output logic counter_enable,
  output logic counter_reinit,
  output logic prescaler_clear,
  output logic irq
);

  // ================================================================
  // register state
  tsf_flags_t flags_r;
  tsf_flags_t flags_nxt;
  tsf_flags_t mask_r;
  logic [31:0] ctrl_r;
  logic [CW-1:0] ccv_r [NCH];
  logic trig_d_r;
  logic [NCH-1:0] cap_d_r;
  logic reinit_r;

  // ================================================================
  // control fields
  logic update_disable;
  logic update_request_source;
  logic [1:0] center_aligned_select;
  tsf_smode_t slave_mode_select;
  logic [NCH-1:0] chan_is_input;
  logic [NCH-1:0] chan_capture_falling;

  assign update_disable = ctrl_r[`TSF_CTRL_UDIS_BIT];
  assign update_request_source = ctrl_r[`TSF_CTRL_URS_BIT];
  assign center_aligned_select = ctrl_r[`TSF_CTRL_CAMS_LSB +: 2];
  assign slave_mode_select = ctrl_r[`TSF_CTRL_SMS_LSB +: 3];
  assign chan_is_input = ctrl_r[`TSF_CTRL_IN_LSB +: NCH];
  assign chan_capture_falling = ctrl_r[`TSF_CTRL_POL_LSB +: NCH];

  // ================================================================
  // axi4-lite write path
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  // address and data are caught independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write decode
  logic wr_ctrl;
  logic wr_mask;
  logic wr_flags;
  logic wr_evgen;
  logic [NCH-1:0] wr_ccv;
  logic wr_hit;
  logic [31:0] wbits;

  always_comb begin
    wr_ctrl = wr_fire && (awaddr_r == `TSF_CTRL_OFS);
    wr_mask = wr_fire && (awaddr_r == `TSF_MASK_OFS);
    wr_flags = wr_fire && (awaddr_r == `TSF_FLAGS_OFS);
    wr_evgen = wr_fire && (awaddr_r == `TSF_EVGEN_OFS);
    for (int i = 0; i < NCH; i++) begin
      wr_ccv[i] = wr_fire && (awaddr_r == `TSF_CCV1_OFS + 12'(i) * `TSF_CCV_STEP);
    end
    wr_hit = wr_ctrl || wr_mask || wr_flags || wr_evgen || (|wr_ccv);
    for (int b = 0; b < 4; b++) begin
      wbits[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : 8'h00;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSF_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `TSF_RESP_OKAY : `TSF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ================================================================
  // axi4-lite read path
  logic rd_fire;
  logic [NCH-1:0] rd_ccv;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rd_ccv[i] = rd_fire && (s_axi_araddr == `TSF_CCV1_OFS + 12'(i) * `TSF_CCV_STEP);
    end
  end

  // read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TSF_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TSF_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr)
        `TSF_CTRL_OFS: s_axi_rdata <= ctrl_r;
        `TSF_MASK_OFS: s_axi_rdata <= {16'h0000, mask_r};
        `TSF_FLAGS_OFS: s_axi_rdata <= {16'h0000, flags_r};
        `TSF_EVGEN_OFS: s_axi_rdata <= 32'h0000_0000; // update bit reads back zero
        default: begin
          if (|rd_ccv) begin
            for (int i = 0; i < NCH; i++) begin
              if (rd_ccv[i]) begin
                s_axi_rdata <= 32'(ccv_r[i]);
              end
            end
          end else begin
            s_axi_rresp <= `TSF_RESP_SLVERR;
          end
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ================================================================
  // control and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 32'h0000_0000;
      mask_r <= `TSF_FLAGS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wbits & `TSF_CTRL_WMASK;
      end
      if (wr_mask) begin
        mask_r <= wbits[15:0] & `TSF_FLAGS_WMASK;
      end
    end
  end

  // ================================================================
  // trigger input and slave controller
  logic trig_rise;
  logic trig_any;
  logic gated;
  logic trig_reinit;
  logic sw_update;

  assign trig_rise = trigger_input && !trig_d_r;
  assign trig_any = trigger_input ^ trig_d_r;
  assign gated = (slave_mode_select == `TSF_SMS_GATED);
  assign trig_reinit = trig_rise && (slave_mode_select == `TSF_SMS_RESET);
  assign sw_update = wr_evgen && wbits[`TSF_EVGEN_UDG_BIT];
  assign counter_enable = gated ? trigger_input : 1'b1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= trigger_input;
    end
  end

  // reinit pulse of one cycle; the generate bit never stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= sw_update || trig_reinit;
    end
  end
  assign counter_reinit = reinit_r;
  assign prescaler_clear = reinit_r;

  // ================================================================
  // per-channel compare and capture events
  logic [NCH-1:0] cc_set;
  logic [NCH-1:0] ovc_set;
  logic [NCH-1:0] cap_event;
  logic [NCH-1:0] cc_rdclr;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic edge_sel;
    logic match;
    logic phase_ok;
    logic beyond;
    assign edge_sel = chan_capture_falling[c] ? (cap_d_r[c] && !chan_capture_input[c])
                                              : (!cap_d_r[c] && chan_capture_input[c]);
    assign cap_event[c] = chan_is_input[c] && edge_sel;
    assign match = counter_tick && (counter_value == ccv_r[c]);
    // center-aligned selection picks the counting direction that flags
    always_comb begin
      case (center_aligned_select)
        `TSF_CAMS_EDGE: phase_ok = 1'b1;
        `TSF_CAMS_DOWN: phase_ok = count_down;
        `TSF_CAMS_UP: phase_ok = !count_down;
        default: phase_ok = 1'b1;
      endcase
    end
    assign beyond = (ccv_r[c] > auto_reload_value) &&
                    ((counter_overflow && (!count_down ||
                      center_aligned_select != `TSF_CAMS_EDGE)) ||
                     (counter_underflow && count_down &&
                      center_aligned_select == `TSF_CAMS_EDGE));
    assign cc_set[c] = chan_is_input[c] ? cap_event[c]
                                        : ((match && phase_ok) || beyond);
    assign ovc_set[c] = cap_event[c] && flags_r[`TSF_CH_BIT0 + c];
    assign cc_rdclr[c] = rd_ccv[c] && chan_is_input[c];

    // capture latches the counter; output mode lets software write it
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ccv_r[c] <= '0;
      end else if (cap_event[c]) begin
        ccv_r[c] <= counter_value;
      end else if (wr_ccv[c] && !chan_is_input[c]) begin
        ccv_r[c] <= wbits[CW-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_d_r <= '0;
    end else begin
      cap_d_r <= chan_capture_input;
    end
  end

  // ================================================================
  // flag register: clear by zero write or capture read, set wins
  tsf_flags_t set_v;
  tsf_flags_t clr_v;

  always_comb begin
    set_v = `TSF_FLAGS_RESET;
    clr_v = `TSF_FLAGS_RESET;
    set_v[`TSF_UPD_BIT] = !update_disable &&
                          (counter_overflow || counter_underflow ||
                           (!update_request_source && (sw_update || trig_reinit)));
    set_v[`TSF_TRIG_BIT] = gated ? trig_any : trig_rise;
    for (int i = 0; i < NCH; i++) begin
      set_v[`TSF_CH_BIT0 + i] = cc_set[i];
      set_v[`TSF_OVC_BIT0 + i] = ovc_set[i];
      clr_v[`TSF_CH_BIT0 + i] = cc_rdclr[i];
    end
    if (wr_flags) begin
      if (wstrb_r[0]) begin
        clr_v[7:0] = clr_v[7:0] | ~wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        clr_v[15:8] = clr_v[15:8] | ~wdata_r[15:8];
      end
    end
    flags_nxt = ((flags_r & ~clr_v) | set_v) & `TSF_FLAGS_WMASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= `TSF_FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // level interrupt while any unmasked flag stands
  assign irq = |(flags_r & mask_r);

endmodule

// File: tsf_checker.sv
// assertion checker for the timer status flag block
`timescale 1ns/10ps
`include "tsf_consts.svh"
// ====================
// checker module
module tsf_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic trigger_input,
  input wire logic counter_enable,
  input wire logic counter_reinit,
  input wire logic prescaler_clear,
  input wire logic irq
);
  logic [11:0] ra_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address of the read under way
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  // ====================
  // properties
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  flag_rsv_a: assert property (s_axi_rvalid && ra_r == `TSF_FLAGS_OFS |->
    s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[8:7] == 2'h0 && !s_axi_rdata[5])
    else $error("reserved flag bit set");
  rst_irq_a: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt after reset");
  gate_en_a: assert property (trigger_input |-> counter_enable)
    else $error("counter stopped with trigger high");
  reinit_pulse_a: assert property (counter_reinit |=> !counter_reinit)
    else $error("reinit longer than one cycle");
  presc_pair_a: assert property (counter_reinit |-> prescaler_clear)
    else $error("prescaler not cleared");
  // main scenarios
  irq_seen_c: cover property ($rose(irq));
  reinit_c: cover property (counter_reinit);
  ovc_rd_c: cover property (s_axi_rvalid && ra_r == `TSF_FLAGS_OFS && s_axi_rdata[9]);
endmodule

bind tsf_timer_status_flags tsf_checker tsf_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .trigger_input(trigger_input),
  .counter_enable(counter_enable), .counter_reinit(counter_reinit),
  .prescaler_clear(prescaler_clear), .irq(irq));

// File: tsf_timer_status_flags_test.sv
// self-checking bench for the timer status flag block
`timescale 1ns/10ps
`define CK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
// ====================
// bench top
module tsf_timer_status_flags_test import tsf_pkg::*;;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb, chan_capture_input;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, counter_tick, count_down;
  logic [15:0] counter_value, auto_reload_value;
  logic counter_overflow, counter_underflow, trigger_input;
  logic counter_enable, counter_reinit, prescaler_clear, irq, ta, tw, tr;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 88;
  int i;
  int n_reinit = 0;
  int n_presc = 0;
  logic [33:0] exp_q[$];
  logic [33:0] got_e;
  logic [1:0] bexp_q[$];
  logic [1:0] got_b;
  tsf_timer_status_flags tsf_timer_status_flags_inst (.*);
  // clock, answer checks against the oldest note, reinit pulse counts
  always #20 aclk = ~aclk;
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      got_e = exp_q.pop_front();
      `CK({s_axi_rresp, s_axi_rdata}, got_e)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      got_b = bexp_q.pop_front();
      `CK(s_axi_bresp, got_b)
    end
    if (counter_reinit) n_reinit++;
    if (prescaler_clear) n_presc++;
  end
  // ====================
  // bus tasks
  // bits 33:32 of d or e carry the expected response code
  task wr(input logic [11:0] a, input logic [33:0] d);
    bexp_q.push_back(d[33:32]);
    s_axi_awaddr <= a;
    s_axi_wdata <= d[31:0];
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  // e is {counter_enable, irq}
  task ckout(input logic [1:0] e);
    @(negedge aclk);
    `CK({counter_enable, irq}, e)
    @(posedge aclk);
  endtask
  task summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge aclk);
    num_errors++;
    summarize;
  end
  // ====================
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, counter_tick, count_down, counter_value} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {counter_overflow, counter_underflow, trigger_input, chan_capture_input} = '0;
    s_axi_wstrb = 4'hf;
    auto_reload_value = 16'hffff;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h010, 32'h0);
    rd(12'h020, 34'h2_0000_0000);
    wr(12'h020, 34'h2_0000_0000);
    $display("reset test done");
    wr(12'h00c, 32'h1e5f);
    counter_overflow <= 1'b1;
    @(posedge aclk);
    counter_overflow <= 1'b0;
    rd(12'h010, 32'h1);
    wr(12'h010, 32'hffff);
    ckout(2'b11);
    wr(12'h00c, 32'h0);
    ckout(2'b10);
    wr(12'h00c, 32'h1e5f);
    wr(12'h010, 32'h0);
    ckout(2'b10);
    wr(12'h000, 32'h1);
    counter_underflow <= 1'b1;
    @(posedge aclk);
    counter_underflow <= 1'b0;
    rd(12'h010, 32'h0);
    wr(12'h000, 32'h0);
    wr(12'h014, 32'h1);
    rd(12'h010, 32'h1);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h2);
    wr(12'h014, 32'h1);
    rd(12'h010, 32'h0);
    $display("update test done");
    wr(12'h000, 32'h400);
    trigger_input <= 1'b1;
    @(posedge aclk);
    rd(12'h010, 32'h41);
    wr(12'h010, 32'h0);
    trigger_input <= 1'b0;
    @(posedge aclk);
    rd(12'h010, 32'h0);
    wr(12'h000, 32'h500);
    ckout(2'b00);
    trigger_input <= 1'b1;
    @(posedge aclk);
    ckout(2'b11);
    wr(12'h010, 32'h0);
    trigger_input <= 1'b0;
    @(posedge aclk);
    rd(12'h010, 32'h40);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h0);
    $display("trigger test done");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(12'h034 + 12'(4 * i), {16'h0, v[15:0]});
      counter_value <= v[15:0];
      counter_tick <= 1'b1;
      @(posedge aclk);
      counter_tick <= 1'b0;
      rd(12'h010, 32'h2 << i);
      wr(12'h010, 32'h0);
    end
    auto_reload_value <= 16'h00ff;
    for (i = 0; i < 4; i++) wr(12'h034 + 12'(4 * i), 32'h0100);
    counter_overflow <= 1'b1;
    @(posedge aclk);
    counter_overflow <= 1'b0;
    rd(12'h010, 32'h1f);
    wr(12'h010, 32'h0);
    $display("compare test done");
    wr(12'h000, 32'hf000);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      counter_value <= v[15:0];
      chan_capture_input <= 4'h1 << i;
      @(posedge aclk);
      chan_capture_input <= 4'h0;
      @(posedge aclk);
      chan_capture_input <= 4'h1 << i;
      @(posedge aclk);
      chan_capture_input <= 4'h0;
      rd(12'h010, (32'h2 << i) | (32'h200 << i));
      rd(12'h034 + 12'(4 * i), {16'h0, v[15:0]});
      rd(12'h010, 32'h200 << i);
      wr(12'h010, 32'h0);
      rd(12'h010, 32'h0);
    end
    $display("capture test done");
    `CK(n_reinit, 3)
    `CK(n_presc, 3)
    summarize;
  end
endmodule
